// >>> logic/usc_consts.svh
// Shared constants of the serial status and control block.
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH
`define USC_AW 12
`define USC_OFS_STATUS 12'h000
`define USC_OFS_TXDATA 12'h004
`define USC_OFS_RXDATA 12'h008
`define USC_OFS_MODE 12'h00c
`define USC_B_TXI_HI 15
`define USC_B_TXINV 14
`define USC_B_TXI_LO 13
`define USC_B_BRK 11
`define USC_B_TXEN 10
`define USC_B_RXI_HI 7
`define USC_B_RXI_LO 6
`define USC_B_ADDRESS_DETECT_ENABLE 5
`define USC_B_OVR 1
`define USC_B_INFRARED_ENCODE_ENABLE 0
`define USC_TXI_EACH 2'h0
`define USC_TXI_DONE 2'h1
`define USC_TXI_EMPTY 2'h2
`define USC_RXI_3Q 2'h2
`define USC_RXI_FULL 2'h3
`define USC_LVL_3Q 3'h3
`define USC_LVL_FULL 3'h4
`define USC_SUB_LAST 4'hf
`define USC_SUB_MID 4'h7
`define USC_IRDA_SUBS 4'h3
`define USC_DATA_BITS 4'h8
`define USC_BREAK_BITS 4'hc
`define USC_RESP_OKAY 2'h0
`define USC_RESP_SLVERR 2'h2
`define USC_TICK_DIV 22
`endif

// >>> logic/usc_pkg.sv
// Types of the serial status and control block.
`include "usc_consts.svh"
package usc_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} usc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} usc_rx_e;
  typedef struct packed {
    logic aw_got;
    logic [`USC_AW-1:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [1:0] tx_mode;
    logic tx_inv;
    logic brk;
    logic txen;
    logic [1:0] rx_mode;
    logic address_detect_enable;
    logic infrared_encode_enable;
    logic rx_overrun_flag;
    logic [15:0] div_cnt;
    logic tick;
    usc_tx_e tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_brk;
    logic tx_lvl;
    logic tx_pin;
    logic tx_irq;
    usc_rx_e rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_irq;
  } usc_top_s;
endpackage

// >>> logic/usc_sync.sv
// Three-stage synchroniser for a pin, with agreement of the last two stages.
module usc_sync #(
  parameter bit RST_VAL = 1'b1
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Pin and synchronised level
  input logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } usc_sync_s;
  usc_sync_s st_ff;
  usc_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // The level only moves once the second and third stages agree.
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.q = st_ff.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= {4{RST_VAL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.q;
endmodule

// >>> logic/usc_fifo.sv
// Small character queue in flip-flops; the head always sits in slot zero.
module usc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int CW = 3
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Fill side
  input logic flush,
  input logic push,
  input logic [W-1:0] push_data,
  // Drain side and state
  input logic pop,
  output logic [W-1:0] head,
  output logic [CW-1:0] count,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0] cnt;
  } usc_fifo_s;
  usc_fifo_s st_ff;
  usc_fifo_s nxt_st;
  logic pop_ok;
  logic push_ok;

  always_comb begin
    nxt_st = st_ff;
    pop_ok = pop && !empty;
    push_ok = push && (!full || pop_ok);
    if (flush) begin
      nxt_st.cnt = '0;
    end else begin
      if (pop_ok) begin
        for (int i = 0; i < DEPTH - 1; i++) begin
          nxt_st.mem[i] = st_ff.mem[i + 1];
        end
      end
      if (push_ok) begin
        nxt_st.mem[CW'(st_ff.cnt - CW'(pop_ok))] = push_data;
      end
      nxt_st.cnt = CW'(st_ff.cnt + CW'(push_ok) - CW'(pop_ok));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign head = st_ff.mem[0];
  assign count = st_ff.cnt;
  assign full = (st_ff.cnt == CW'(DEPTH));
  assign empty = (st_ff.cnt == '0);
endmodule

// >>> logic/usc_top.sv
// Serial port status and control logic behind an AXI4-Lite register slave.
// Behaviour
// R1: TX mode 10 raises TX interrupt when a load leaves the buffer empty.
// R2: TX mode 01 raises TX interrupt when the last character fully leaves.
// R3: TX mode 00 raises TX interrupt on every load into the shift register.
// R4: Software never programs TX mode 11; it raises no interrupt here.
// R5: Without infrared, TX idles low when inverted, high otherwise.
// R6: With infrared, TX carries pulses and idles high when inverted, low otherwise.
// R7: A break request sends start bit, twelve zero bits, then stop bit.
// R8: Hardware clears the break request when the break sequence finishes.
// R9: Transmit enable hands the TX pin to the port; otherwise released.
// R10: Clearing transmit enable aborts transmission and empties the buffer.
// R11: Buffer-full flag reads 1 only when no more characters fit.
// R12: Shift-empty flag reads 1 only when shifter and buffer are idle; resets 1.
// R13: RX mode 11 raises RX interrupt when a transfer makes four characters.
// R14: RX mode 10 raises RX interrupt when a transfer makes three characters.
// R15: RX mode 0x raises RX interrupt on every received character; here a character dropped into a full buffer raises none.
// R16: Status bit 12 always reads zero and ignores writes.
// R17: Data-available flag reads 1 while any unread character is buffered.
// R18: Overrun sets when a character ends into a full buffer; cleared by writing 0.
`include "usc_consts.svh"
module usc_top #(
  parameter int TICK_DIV = `USC_TICK_DIV,
  parameter int TX_DEPTH = 4,
  parameter int RX_DEPTH = 4
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write address
  input logic awvalid,
  output logic awready,
  input logic [`USC_AW-1:0] awaddr,
  input logic [2:0] awprot,
  // AXI4-Lite write data
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input logic arvalid,
  output logic arready,
  input logic [`USC_AW-1:0] araddr,
  input logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial pins
  input logic serial_rx_in,
  output logic serial_tx_out,
  output logic serial_tx_oe_n,
  // Interrupt pulses
  output logic tx_irq,
  output logic rx_irq
);
  localparam int TXC = $clog2(TX_DEPTH + 1);
  localparam int RXC = $clog2(RX_DEPTH + 1);

  usc_pkg::usc_top_s st_ff;
  usc_pkg::usc_top_s nxt_st;
  logic tx_push;
  logic tx_pop;
  logic tx_done;
  logic tx_full;
  logic tx_empty;
  logic [TXC-1:0] tx_cnt;
  logic [TXC-1:0] tx_after;
  logic [7:0] tx_head;
  logic rx_s;
  logic rx_push;
  logic rx_pop;
  logic rx_done;
  logic rx_full;
  logic rx_empty;
  logic [RXC-1:0] rx_cnt;
  logic [RXC-1:0] rx_after;
  logic [8:0] rx_head;
  logic [8:0] rx_word;
  logic stat_wr;
  logic zero_now;
  logic [15:0] stat_word;

  function automatic logic rx_irq_hit(input logic [1:0] mode, input logic [RXC-1:0] after);
    case (mode)
      `USC_RXI_FULL: rx_irq_hit = (after == RXC'(`USC_LVL_FULL));
      `USC_RXI_3Q: rx_irq_hit = (after == RXC'(`USC_LVL_3Q));
      default: rx_irq_hit = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Queues and pin synchroniser.

  usc_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(serial_rx_in),
    .level(rx_s)
  );

  usc_fifo #(.W(8), .DEPTH(TX_DEPTH), .CW(TXC)) u_tx_queue (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!st_ff.txen),
    .push(tx_push),
    .push_data(st_ff.wdata[7:0]),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_cnt),
    .full(tx_full),
    .empty(tx_empty)
  );

  usc_fifo #(.W(9), .DEPTH(RX_DEPTH), .CW(RXC)) u_rx_queue (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(1'b0),
    .push(rx_push),
    .push_data(rx_word),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_cnt),
    .full(rx_full),
    .empty(rx_empty)
  );

  // Status word; bit 3 stays zero because no parity is checked.
  // R11: buffer full flag
  // R17: data available flag
  // R16: bit twelve zero
  assign stat_word = {st_ff.tx_mode[1], st_ff.tx_inv, st_ff.tx_mode[0], 1'b0, st_ff.brk,
                      st_ff.txen, tx_full, tx_empty && (st_ff.tx_st == usc_pkg::TX_IDLE),
                      st_ff.rx_mode, st_ff.address_detect_enable, st_ff.rx_st == usc_pkg::RX_IDLE, 1'b0,
                      rx_head[8] && !rx_empty, st_ff.rx_overrun_flag, !rx_empty};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    nxt_st = st_ff;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_done = 1'b0;
    rx_pop = 1'b0;
    rx_done = 1'b0;
    rx_word = {1'b0, st_ff.rx_sh};
    stat_wr = 1'b0;
    zero_now = 1'b0;
    nxt_st.tx_irq = 1'b0;
    nxt_st.rx_irq = 1'b0;
    nxt_st.tick = 1'b0;
    // Write channel: address and data are taken in either order.
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata[15:0];
      nxt_st.wstrb = wstrb[1:0];
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `USC_RESP_OKAY;
      case (st_ff.awaddr)
        `USC_OFS_STATUS: begin
          stat_wr = 1'b1;
          if (st_ff.wstrb[1]) begin
            nxt_st.tx_mode = {st_ff.wdata[`USC_B_TXI_HI], st_ff.wdata[`USC_B_TXI_LO]};
            nxt_st.tx_inv = st_ff.wdata[`USC_B_TXINV];
            nxt_st.brk = st_ff.wdata[`USC_B_BRK];
            nxt_st.txen = st_ff.wdata[`USC_B_TXEN];
          end
          if (st_ff.wstrb[0]) begin
            nxt_st.rx_mode = st_ff.wdata[`USC_B_RXI_HI:`USC_B_RXI_LO];
            nxt_st.address_detect_enable = st_ff.wdata[`USC_B_ADDRESS_DETECT_ENABLE];
            // R18: software clears only
            if (!st_ff.wdata[`USC_B_OVR]) begin
              nxt_st.rx_overrun_flag = 1'b0;
            end
          end
        end
        `USC_OFS_TXDATA: begin
          tx_push = st_ff.wstrb[0] && st_ff.txen && !tx_full;
        end
        `USC_OFS_MODE: begin
          if (st_ff.wstrb[0]) begin
            nxt_st.infrared_encode_enable = st_ff.wdata[`USC_B_INFRARED_ENCODE_ENABLE];
          end
        end
        `USC_OFS_RXDATA: begin
          nxt_st.bresp = `USC_RESP_OKAY;
        end
        default: begin
          nxt_st.bresp = `USC_RESP_SLVERR;
        end
      endcase
    end
    // Read channel; reading the receive data register takes the head character.
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `USC_RESP_OKAY;
      nxt_st.rdata = '0;
      case (araddr)
        `USC_OFS_STATUS: nxt_st.rdata = stat_word;
        `USC_OFS_TXDATA: nxt_st.rdata = '0;
        `USC_OFS_RXDATA: begin
          nxt_st.rdata = 16'(rx_head);
          rx_pop = !rx_empty;
        end
        `USC_OFS_MODE: nxt_st.rdata = 16'(st_ff.infrared_encode_enable);
        default: nxt_st.rresp = `USC_RESP_SLVERR;
      endcase
    end
    // Sixteen ticks per bit.
    if (st_ff.div_cnt == 16'(TICK_DIV - 1)) begin
      nxt_st.div_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 16'h1;
    end
    // R10: disable aborts
    if (!st_ff.txen) begin
      nxt_st.tx_st = usc_pkg::TX_IDLE;
      nxt_st.tx_lvl = 1'b1;
      nxt_st.tx_brk = 1'b0;
      nxt_st.tx_sub = '0;
      nxt_st.brk = nxt_st.brk && nxt_st.txen;
    end else begin
      case (st_ff.tx_st)
        usc_pkg::TX_IDLE: begin
          nxt_st.tx_sub = '0;
          nxt_st.tx_lvl = 1'b1;
          // R7: break takes next slot
          if (st_ff.brk) begin
            nxt_st.tx_st = usc_pkg::TX_START;
            nxt_st.tx_brk = 1'b1;
            nxt_st.tx_lvl = 1'b0;
          end else if (!tx_empty) begin
            tx_pop = 1'b1;
            nxt_st.tx_sh = tx_head;
            nxt_st.tx_st = usc_pkg::TX_START;
            nxt_st.tx_brk = 1'b0;
            nxt_st.tx_lvl = 1'b0;
          end
        end
        usc_pkg::TX_START: begin
          if (st_ff.tick) begin
            nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
            if (st_ff.tx_sub == `USC_SUB_LAST) begin
              nxt_st.tx_st = usc_pkg::TX_BITS;
              nxt_st.tx_bit = '0;
              nxt_st.tx_lvl = !st_ff.tx_brk && st_ff.tx_sh[0];
            end
          end
        end
        usc_pkg::TX_BITS: begin
          if (st_ff.tick) begin
            nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
            if (st_ff.tx_sub == `USC_SUB_LAST) begin
              // R7: twelve zero bits
              if ((st_ff.tx_bit + 4'h1) == (st_ff.tx_brk ? `USC_BREAK_BITS : `USC_DATA_BITS)) begin
                nxt_st.tx_st = usc_pkg::TX_STOP;
                nxt_st.tx_lvl = 1'b1;
              end else begin
                nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                nxt_st.tx_sh = st_ff.tx_sh >> 1;
                nxt_st.tx_lvl = !st_ff.tx_brk && st_ff.tx_sh[1];
              end
            end
          end
        end
        usc_pkg::TX_STOP: begin
          if (st_ff.tick) begin
            nxt_st.tx_sub = st_ff.tx_sub + 4'h1;
            if (st_ff.tx_sub == `USC_SUB_LAST) begin
              nxt_st.tx_st = usc_pkg::TX_IDLE;
              tx_done = 1'b1;
              // R8: hardware clears break
              if (st_ff.tx_brk) begin
                nxt_st.brk = 1'b0;
                nxt_st.tx_brk = 1'b0;
              end
            end
          end
        end
        default: nxt_st.tx_st = usc_pkg::TX_IDLE;
      endcase
    end
    tx_after = TXC'(tx_cnt + TXC'(tx_push) - TXC'(tx_pop));
    case (st_ff.tx_mode)
      // R3: each load
      `USC_TXI_EACH: nxt_st.tx_irq = tx_pop;
      // R1: load empties buffer
      `USC_TXI_EMPTY: nxt_st.tx_irq = tx_pop && (tx_after == '0);
      // R2: all sent
      `USC_TXI_DONE: nxt_st.tx_irq = tx_done && tx_empty;
      // R4: reserved mode silent
      default: nxt_st.tx_irq = 1'b0;
    endcase
    // Pin level: plain NRZ, or a short pulse per zero bit when infrared is on.
    zero_now = (st_ff.tx_st != usc_pkg::TX_IDLE) && !st_ff.tx_lvl;
    if (st_ff.infrared_encode_enable) begin
      // R6: infrared pulse and idle
      nxt_st.tx_pin = (zero_now && (st_ff.tx_sub < `USC_IRDA_SUBS)) ? !st_ff.tx_inv
                                                                       : st_ff.tx_inv;
    end else begin
      // R5: plain idle polarity
      nxt_st.tx_pin = st_ff.tx_lvl ^ st_ff.tx_inv;
    end
    // Receiver: start bit is qualified at mid-bit, data sampled every sixteen ticks.
    case (st_ff.rx_st)
      usc_pkg::RX_IDLE: begin
        nxt_st.rx_sub = '0;
        if (!rx_s) begin
          nxt_st.rx_st = usc_pkg::RX_START;
        end
      end
      usc_pkg::RX_START: begin
        if (st_ff.tick) begin
          nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          if (st_ff.rx_sub == `USC_SUB_MID) begin
            nxt_st.rx_st = rx_s ? usc_pkg::RX_IDLE : usc_pkg::RX_BITS;
            nxt_st.rx_sub = '0;
            nxt_st.rx_bit = '0;
          end
        end
      end
      usc_pkg::RX_BITS: begin
        if (st_ff.tick) begin
          nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          if (st_ff.rx_sub == `USC_SUB_LAST) begin
            nxt_st.rx_sh = {rx_s, st_ff.rx_sh[7:1]};
            nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
            if ((st_ff.rx_bit + 4'h1) == `USC_DATA_BITS) begin
              nxt_st.rx_st = usc_pkg::RX_STOP;
            end
          end
        end
      end
      usc_pkg::RX_STOP: begin
        if (st_ff.tick) begin
          nxt_st.rx_sub = st_ff.rx_sub + 4'h1;
          if (st_ff.rx_sub == `USC_SUB_LAST) begin
            rx_done = 1'b1;
            rx_word = {!rx_s, st_ff.rx_sh};
            nxt_st.rx_st = usc_pkg::RX_IDLE;
          end
        end
      end
      default: nxt_st.rx_st = usc_pkg::RX_IDLE;
    endcase
    rx_push = rx_done && !rx_full;
    rx_after = RXC'(rx_cnt + RXC'(rx_push) - RXC'(rx_pop));
    // R13: four characters
    // R14: three characters
    // R15: any character
    nxt_st.rx_irq = rx_push && rx_irq_hit(st_ff.rx_mode, rx_after);
    // R18: overrun set wins
    if (rx_done && rx_full) begin
      nxt_st.rx_overrun_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.tx_lvl <= 1'b1;
      st_ff.tx_pin <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign awready = !st_ff.aw_got && !st_ff.bvalid;
  assign wready = !st_ff.w_got && !st_ff.bvalid;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = !st_ff.rvalid;
  assign rvalid = st_ff.rvalid;
  assign rdata = 32'(st_ff.rdata);
  assign rresp = st_ff.rresp;
  assign serial_tx_out = st_ff.tx_pin;
  // R9: pin owned when enabled
  assign serial_tx_oe_n = !st_ff.txen;
  assign tx_irq = st_ff.tx_irq;
  assign rx_irq = st_ff.rx_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_brk_start;
    st_ff.txen && st_ff.brk && (st_ff.tx_st == usc_pkg::TX_IDLE);
  endsequence
  sequence s_brk_run;
    (st_ff.tx_st == usc_pkg::TX_START) && st_ff.tx_brk;
  endsequence

  a_tx_each_load: assert property ((tx_pop && st_ff.tx_mode == `USC_TXI_EACH) |=> tx_irq) // R3
    else $error("tx interrupt missing on load");
  a_tx_empty_load: assert property ((tx_irq && $past(st_ff.tx_mode) == `USC_TXI_EMPTY) // R1
    |-> $past(tx_pop) && $past(tx_after) == '0) else $error("tx empty interrupt without cause");
  a_tx_all_sent: assert property ((tx_done && tx_empty && st_ff.tx_mode == `USC_TXI_DONE) // R2
    |=> tx_irq) else $error("tx done interrupt missing");
  a_idle_plain: assert property (((st_ff.txen && !st_ff.infrared_encode_enable // R5
    && st_ff.tx_st == usc_pkg::TX_IDLE && $stable(st_ff.tx_inv))[*2])
    |-> serial_tx_out == !st_ff.tx_inv) else $error("plain idle level wrong");
  a_idle_irda: assert property (((st_ff.txen && st_ff.infrared_encode_enable // R6
    && st_ff.tx_st == usc_pkg::TX_IDLE && $stable(st_ff.tx_inv))[*2])
    |-> serial_tx_out == st_ff.tx_inv) else $error("infrared idle level wrong");
  a_brk_begin: assert property (s_brk_start |=> s_brk_run) // R7
    else $error("break did not start");
  a_brk_zeros: assert property ((st_ff.tx_brk && st_ff.tx_st == usc_pkg::TX_BITS) // R7
    |-> !st_ff.tx_lvl) else $error("break bit not zero");
  a_brk_hw_clear: assert property (($fell(st_ff.brk) && $past(st_ff.txen) && !$past(stat_wr)) // R8
    |-> $past(tx_done) && $past(st_ff.tx_brk)) else $error("break cleared early");
  a_abort_flush: assert property (!st_ff.txen |=> tx_empty // R10
    && st_ff.tx_st == usc_pkg::TX_IDLE) else $error("abort left transmit busy");
  a_full_flag: assert property (((tx_push && !tx_pop && tx_cnt == TXC'(TX_DEPTH - 1)) // R11
    |=> stat_word[9]) and ((tx_pop && tx_full) |=> !stat_word[9]))
    else $error("buffer full flag wrong");
  a_shift_empty: assert property (stat_word[8] |-> tx_empty && !st_ff.tx_brk) // R12
    else $error("shift empty flag wrong");
  a_rx_full_irq: assert property ((rx_push && st_ff.rx_mode == `USC_RXI_FULL // R13
    && rx_after == RXC'(`USC_LVL_FULL)) |=> rx_irq) else $error("rx full interrupt missing");
  a_rx_3q_irq: assert property ((rx_irq && $past(st_ff.rx_mode) == `USC_RXI_3Q) // R14
    |-> $past(rx_after) == RXC'(`USC_LVL_3Q)) else $error("rx three interrupt wrong");
  a_rx_any_irq: assert property ((rx_push && !st_ff.rx_mode[1]) |=> rx_irq) // R15
    else $error("rx interrupt missing");
  a_bit12_zero: assert property (!stat_word[12]) // R16
    else $error("status bit twelve not zero");
  a_rx_avail: assert property ((rx_push |=> stat_word[0]) // R17
    and ((rx_pop && !rx_push && rx_cnt == RXC'(1)) |=> !stat_word[0]))
    else $error("data available flag wrong");
  a_overrun_set: assert property ((rx_done && rx_full) |=> st_ff.rx_overrun_flag) // R18
    else $error("overrun not flagged");
endmodule

// >>> tb/usc_node.sv
// Remote serial node model that decodes transmitted frames and sends frames.
module usc_node #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic aclk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [$];
  logic [7:0] b;
  realtime fall_t;
  realtime low_ns;
  initial rx_line = 1'b1;
  // Low spans are timed so that a long break can be measured.
  always @(negedge tx_line) fall_t = $realtime;
  always @(posedge tx_line) low_ns = $realtime - fall_t;
  always begin
    @(negedge tx_line);
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge aclk);
      if (i < 8) b[i] = tx_line;
    end
    got.push_back(b);
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      rx_line <= f[i];
      repeat (BIT - 1) @(posedge aclk);
    end
  endtask
endmodule

// >>> tb/usc_top_bench.sv
// Self-checking bench of the serial status and control block.
`include "usc_consts.svh"
module usc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, serial_rx_in;
  logic awready, wready, bvalid, arready, rvalid, serial_tx_out, serial_tx_oe_n;
  logic tx_irq, rx_irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] rd_v;
  int num_errors, cmp_count, ntx, nrx;
  usc_top #(.TICK_DIV(1)) uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .serial_rx_in, .serial_tx_out,
    .serial_tx_oe_n, .tx_irq, .rx_irq);
  usc_node #(.BIT(16)) node (.aclk, .tx_line(serial_tx_out), .rx_line(serial_rx_in));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (tx_irq === 1'b1) ntx++;
    if (rx_irq === 1'b1) nrx++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      if (awvalid && awready) ad = 1'b1;
      if (wvalid && wready) dd = 1'b1;
      @(posedge aclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata[15:0];
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic rs(input logic [15:0] e);
    rd(`USC_OFS_STATUS);
    chk("status", e, rd_v);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("oe_n", 16'h1, {15'h0, serial_tx_oe_n});
    rs(16'h0110);
    wr(`USC_OFS_STATUS, 16'h1002);
    chk("bresp", {14'h0, `USC_RESP_OKAY}, {14'h0, r});
    rs(16'h0110);
    wr(12'h010, 16'h0400);
    chk("bresp", {14'h0, `USC_RESP_SLVERR}, {14'h0, r});
    rd(12'h010);
    chk("resp", {14'h0, `USC_RESP_SLVERR}, {14'h0, r});
  endtask
  task automatic t_txmode(input logic [1:0] m, input int e5, input int ee);
    logic [15:0] mb;
    mb = {m[1], 1'b0, m[0], 13'h0400};
    wr(`USC_OFS_STATUS, mb);
    node.got.delete();
    ntx = 0;
    for (int i = 0; i < 5; i++) wr(`USC_OFS_TXDATA, 16'h00a0 + 16'(i));
    rs(mb | 16'h0210);
    while (node.got.size() < 5) @(posedge aclk);
    chk("tx_irq mid", 16'(e5), 16'(ntx));
    repeat (40) @(posedge aclk);
    chk("tx_irq end", 16'(ee), 16'(ntx));
    for (int i = 0; i < 5; i++) chk("txd", 16'h00a0 + 16'(i), {8'h0, node.got[i]});
    rs(mb | 16'h0110);
  endtask
  task automatic t_abort;
    wr(`USC_OFS_STATUS, 16'h0400);
    repeat (3) wr(`USC_OFS_TXDATA, 16'h0055);
    wr(`USC_OFS_STATUS, 16'h0000);
    rs(16'h0110);
    chk("oe_n", 16'h1, {15'h0, serial_tx_oe_n});
  endtask
  task automatic t_break;
    wr(`USC_OFS_STATUS, 16'h0c00);
    rd(`USC_OFS_STATUS);
    chk("brk", 16'h0800, rd_v & 16'h0800);
    repeat (260) @(posedge aclk);
    chk("brk_low", 16'h00d0, 16'(int'(node.low_ns / 25.0)));
    rs(16'h0510);
  endtask
  task automatic t_rx(input logic [1:0] m, input int e3, input int e4);
    logic [15:0] mb;
    mb = {8'h01, m, 6'h10};
    wr(`USC_OFS_STATUS, mb);
    nrx = 0;
    for (int i = 0; i < 5; i++) begin
      node.send(8'h3c + 8'(i));
      repeat (4) @(posedge aclk);
      if (i == 2) chk("rx_irq 3", 16'(e3), 16'(nrx));
      if (i == 3) chk("rx_irq 4", 16'(e4), 16'(nrx));
    end
    rs(mb | 16'h0003);
    wr(`USC_OFS_STATUS, mb);
    rs(mb | 16'h0001);
    for (int i = 0; i < 4; i++) begin
      rd(`USC_OFS_RXDATA);
      chk("rxd", 16'h003c + 16'(i), rd_v);
    end
    rs(mb);
  endtask
  task automatic t_pol;
    int lo;
    for (int k = 0; k < 4; k++) begin
      wr(`USC_OFS_MODE, {15'h0, k[1]});
      wr(`USC_OFS_STATUS, {1'b0, k[0], 14'h0400});
      repeat (4) @(posedge aclk);
      chk("idle", {15'h0, ~(k[1] ^ k[0])}, {15'h0, serial_tx_out});
    end
    wr(`USC_OFS_TXDATA, 16'h00f0);
    lo = 0;
    repeat (200) begin
      @(posedge aclk);
      if (serial_tx_out === 1'b0) lo++;
    end
    chk("irda_low", 16'(5 * `USC_IRDA_SUBS), 16'(lo));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_txmode(2'h0, 5, 5);
    t_txmode(2'h1, 0, 1);
    t_txmode(2'h2, 2, 2);
    t_abort();
    t_break();
    t_rx(2'h0, 3, 4);
    t_rx(2'h1, 3, 4);
    t_rx(2'h2, 1, 1);
    t_rx(2'h3, 0, 1);
    t_pol();
    give_verdict();
  end
endmodule
